// ==== pnpcr_host.sv ====
// host side of the configuration port: device number, index, strobes
// assumes the bench calls its tasks from a single process
`timescale 1ns/1ps
module pnpcr_host (
	input wire logic mclk_in, // bank clock
	input wire logic [7:0] rdata_in, // read data from the bank
	output logic [7:0] ldn_out, // selected logical device
	output logic [7:0] index_out, // register index
	output logic [7:0] wdata_out, // write data
	output logic wr_out, // write strobe
	output logic rd_out // read strobe
);
	// idle port before the first transfer
	initial begin
		ldn_out = 8'h00;
		index_out = 8'h00;
		wdata_out = 8'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
	end
	// one strobe cycle; released index and data lines show inverted values, ldn_out keeps its value
	task automatic xfer(input logic w, input logic [7:0] l, i, d);
		@(posedge mclk_in);
		#1;
		ldn_out = l;
		index_out = i;
		wdata_out = d;
		wr_out = w;
		rd_out = !w;
		@(posedge mclk_in);
		#1;
		wr_out = 1'b0;
		rd_out = 1'b0;
		index_out = ~i;
		wdata_out = ~d;
	endtask
	// read data is settled just after the edge that takes the strobe
	task automatic rd(input logic [7:0] l, i, output logic [7:0] d);
		xfer(1'b0, l, i, 8'h00);
		d = rdata_in;
	endtask
endmodule

// ==== pnpcr_pkg.sv ====
// constants and carriers for the logical device configuration registers
// assumes an 8-bit configuration index/data path and a logical device number
// supplied by the card control logic outside this block
package pnpcr_pkg;

	// configuration indexes inside one logical device
	localparam logic [7:0] IDX_ACTIVATE = 8'h30;
	localparam logic [7:0] IDX_RANGE_CHECK = 8'h31;
	localparam logic [7:0] IDX_BASE_HIGH = 8'h60;
	localparam logic [7:0] IDX_BASE_LOW = 8'h61;
	localparam logic [7:0] IDX_IRQ_SELECT = 8'h70;
	localparam logic [7:0] IDX_IRQ_TYPE = 8'h71;
	localparam logic [7:0] IDX_DMA0 = 8'h74;
	localparam logic [7:0] IDX_DMA1 = 8'h75;
	localparam logic [7:0] IDX_DEVICE_CONFIG = 8'hF0;
	localparam logic [7:0] IDX_DRIVE_IDENT = 8'hF1;

	// logical device numbers served; slot = number minus the first
	localparam logic [7:0] LDN_FDC = 8'h03;
	localparam logic [7:0] LDN_SER1 = 8'h06;
	localparam int NUM_DEV = 4;
	localparam logic [1:0] SLOT_FDC = 2'h0;
	localparam logic [1:0] SLOT_LPT = 2'h1;

	// one byte per device, slot 0 (floppy) in the low byte
	typedef logic [3:0][7:0] pnpcr_bytes_t;

	// values after reset, order {ser1, ser2, lpt, fdc}
	localparam pnpcr_bytes_t RST_ACTIVATE = {8'h00, 8'h00, 8'h00, 8'h00};
	localparam pnpcr_bytes_t RST_RANGE = {8'h00, 8'h00, 8'h00, 8'h00};
	localparam pnpcr_bytes_t RST_BASE_HIGH = {8'h03, 8'h02, 8'h02, 8'h03};
	localparam pnpcr_bytes_t RST_BASE_LOW = {8'hF8, 8'hF8, 8'h78, 8'hF2};
	localparam pnpcr_bytes_t RST_IRQ_SELECT = {8'h04, 8'h03, 8'h07, 8'h06};
	localparam pnpcr_bytes_t RST_IRQ_TYPE = {8'h03, 8'h03, 8'h00, 8'h03};
	localparam pnpcr_bytes_t RST_DMA0 = {8'h04, 8'h04, 8'h04, 8'h02};
	localparam pnpcr_bytes_t RST_DMA1 = {8'h04, 8'h04, 8'h04, 8'h04};
	// device configuration bytes load only on hard reset
	localparam pnpcr_bytes_t RST_DEVICE_CONFIG = {8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] RST_DRIVE_IDENT = 8'h00;

	// host-writable bits; the rest keep their reset value
	localparam pnpcr_bytes_t WM_BASE_HIGH = {8'hFF, 8'hFF, 8'h03, 8'hFF};
	localparam pnpcr_bytes_t WM_BASE_LOW = {8'hF8, 8'hF8, 8'hFC, 8'hFA};
	localparam pnpcr_bytes_t WM_IRQ_TYPE = {8'h02, 8'h02, 8'h02, 8'h02};
	localparam pnpcr_bytes_t WM_DMA0 = {8'h00, 8'hFF, 8'hFF, 8'hFF};
	localparam pnpcr_bytes_t WM_DMA1 = {8'h00, 8'hFF, 8'h00, 8'h00};

	// resources handed to the device logic
	typedef struct packed {
		pnpcr_bytes_t base_high;
		pnpcr_bytes_t base_low;
		pnpcr_bytes_t irq_select;
		pnpcr_bytes_t irq_type;
		pnpcr_bytes_t dma0;
		pnpcr_bytes_t dma1;
		pnpcr_bytes_t device_config;
		logic [7:0] drive_ident;
	} pnpcr_res_s;

	// whole state of the register bank
	typedef struct packed {
		pnpcr_res_s res;
		pnpcr_bytes_t activate;
		pnpcr_bytes_t range_check;
		logic [3:0] dev_enable;
		logic strap_done;
		logic [7:0] rdata;
		logic rvalid;
	} pnpcr_state_s;

endpackage

// ==== pnpcr_regs.sv ====
// configuration register sets of logical devices 3 to 6
// assumes the index, data and logical device number come synchronous to
// mclk_in from the configuration port logic; nrst_in is the hard reset
//
// Overview of operation
// - floppy base low: bits 2,0 zero, F2h
// - floppy irq type: only bit 1 writable, 03h
// - floppy activate from strap, gated by function enable
// - F0h/F1h reset only by hard reset
// - parallel base high: bits 7-2 zero, 02h
// - parallel base low: bits 1,0 zero, 78h
// - parallel irq type bit 0 shows extended mode
// - parallel irq type: bit 1 writable, 00h
// - second serial base low: bits 2-0 zero
// - second serial: separate rx/tx dma selects
// - second serial irq type: bit 1 writable
// - first serial base: F8h low, 03h high
// - first serial irq type: bit 1 writable
// - first serial dma indexes fixed at 04h
// - inactive device: runtime blocked, contents kept
`timescale 1ns/1ps
module pnpcr_regs (
	input wire logic mclk_in, // 125 MHz clock
	input wire logic nrst_in, // hard reset, active low
	input wire logic soft_reset_in, // soft reset pulse
	input wire logic [7:0] ldn_in, // selected logical device number
	input wire logic [7:0] cfg_index_in, // configuration index
	input wire logic [7:0] cfg_wdata_in, // write data
	input wire logic cfg_wr_in, // write strobe
	input wire logic cfg_rd_in, // read strobe
	input wire logic config_strap_zero_in, // activate strap level
	input wire logic [3:0] function_enable_one_in, // per-device enables
	input wire logic lpt_extended_mode_in, // parallel port in extended mode
	output logic [7:0] cfg_rdata_out, // read data
	output logic cfg_rvalid_out, // read data valid pulse
	output logic [3:0] dev_enable_out, // runtime access allowed
	output pnpcr_pkg::pnpcr_res_s res_out // resources of each device
);

	pnpcr_pkg::pnpcr_state_s s;
	pnpcr_pkg::pnpcr_state_s next_s;

	// selected device decode, shared by read and write paths
	function automatic logic [2:0] slot_of(input logic [7:0] ldn);
		logic [7:0] diff;
		logic hit;
		diff = ldn - pnpcr_pkg::LDN_FDC;
		hit = (ldn >= pnpcr_pkg::LDN_FDC) && (ldn <= pnpcr_pkg::LDN_SER1);
		return {hit, diff[1:0]};
	endfunction

	// masked update keeps read-only bits at their fixed value
	function automatic logic [7:0] merge(input logic [7:0] old,
		input logic [7:0] wd, input logic [7:0] wm);
		return (old & ~wm) | (wd & wm);
	endfunction

	logic [2:0] sel;
	logic [1:0] slot;
	logic hit;
	logic [7:0] rd_val;

	assign sel = slot_of(ldn_in);
	assign hit = sel[2];
	assign slot = sel[1:0];

	// read mux; anything unmapped or unselected reads 00h
	always_comb begin
		rd_val = 8'h00;
		case (cfg_index_in)
			pnpcr_pkg::IDX_ACTIVATE: rd_val = s.activate[slot];
			pnpcr_pkg::IDX_RANGE_CHECK: rd_val = s.range_check[slot];
			pnpcr_pkg::IDX_BASE_HIGH: rd_val = s.res.base_high[slot];
			pnpcr_pkg::IDX_BASE_LOW: rd_val = s.res.base_low[slot];
			pnpcr_pkg::IDX_IRQ_SELECT: rd_val = s.res.irq_select[slot];
			pnpcr_pkg::IDX_IRQ_TYPE: begin
				rd_val = s.res.irq_type[slot];
				if (slot == pnpcr_pkg::SLOT_LPT) begin
					rd_val[0] = lpt_extended_mode_in;
				end
			end
			pnpcr_pkg::IDX_DMA0: rd_val = s.res.dma0[slot];
			pnpcr_pkg::IDX_DMA1: rd_val = s.res.dma1[slot];
			pnpcr_pkg::IDX_DEVICE_CONFIG: rd_val = s.res.device_config[slot];
			pnpcr_pkg::IDX_DRIVE_IDENT: begin
				if (slot == pnpcr_pkg::SLOT_FDC) begin
					rd_val = s.res.drive_ident;
				end
			end
			default: rd_val = 8'h00;
		endcase
		if (!hit) begin
			rd_val = 8'h00;
		end
	end

	// next state: soft reset, strap capture, host writes
	always_comb begin
		next_s = s;
		next_s.rvalid = cfg_rd_in;
		if (cfg_rd_in) begin
			next_s.rdata = rd_val;
		end
		if (soft_reset_in) begin
			// shared reset values load on soft reset too; F0h/F1h stay
			next_s.range_check = pnpcr_pkg::RST_RANGE;
			next_s.res.base_high = pnpcr_pkg::RST_BASE_HIGH;
			next_s.res.base_low = pnpcr_pkg::RST_BASE_LOW;
			next_s.res.irq_select = pnpcr_pkg::RST_IRQ_SELECT;
			next_s.res.irq_type = pnpcr_pkg::RST_IRQ_TYPE;
			next_s.res.dma0 = pnpcr_pkg::RST_DMA0;
			next_s.res.dma1 = pnpcr_pkg::RST_DMA1;
			next_s.activate = pnpcr_pkg::RST_ACTIVATE;
			next_s.strap_done = 1'b0;
		end else if (!s.strap_done) begin
			// strap sampled after release, never under the async reset
			next_s.activate[pnpcr_pkg::SLOT_FDC] =
				{7'h00, config_strap_zero_in};
			next_s.strap_done = 1'b1;
		end else if (cfg_wr_in && hit) begin
			case (cfg_index_in)
				pnpcr_pkg::IDX_ACTIVATE:
					next_s.activate[slot] = cfg_wdata_in;
				pnpcr_pkg::IDX_RANGE_CHECK:
					next_s.range_check[slot] = cfg_wdata_in;
				pnpcr_pkg::IDX_BASE_HIGH:
					next_s.res.base_high[slot] = merge(s.res.base_high[slot],
						cfg_wdata_in, pnpcr_pkg::WM_BASE_HIGH[slot]);
				pnpcr_pkg::IDX_BASE_LOW:
					next_s.res.base_low[slot] = merge(s.res.base_low[slot],
						cfg_wdata_in,
						pnpcr_pkg::WM_BASE_LOW[slot]);
				pnpcr_pkg::IDX_IRQ_SELECT:
					next_s.res.irq_select[slot] = cfg_wdata_in;
				pnpcr_pkg::IDX_IRQ_TYPE:
					next_s.res.irq_type[slot] = merge(s.res.irq_type[slot],
						cfg_wdata_in,
						pnpcr_pkg::WM_IRQ_TYPE[slot]);
				pnpcr_pkg::IDX_DMA0:
					next_s.res.dma0[slot] = merge(s.res.dma0[slot],
						cfg_wdata_in, pnpcr_pkg::WM_DMA0[slot]);
				pnpcr_pkg::IDX_DMA1:
					next_s.res.dma1[slot] = merge(s.res.dma1[slot],
						cfg_wdata_in, pnpcr_pkg::WM_DMA1[slot]);
				pnpcr_pkg::IDX_DEVICE_CONFIG:
					next_s.res.device_config[slot] = cfg_wdata_in;
				pnpcr_pkg::IDX_DRIVE_IDENT: begin
					if (slot == pnpcr_pkg::SLOT_FDC) begin
						next_s.res.drive_ident = cfg_wdata_in;
					end
				end
				default: ;
			endcase
		end
		// runtime decode opens only while active and function-enabled;
		// clearing it never touches the stored registers
		for (int i = 0; i < pnpcr_pkg::NUM_DEV; i++) begin
			next_s.dev_enable[i] = next_s.activate[i][0] &
				function_enable_one_in[i];
		end
	end

	// state register; async reset takes constants only
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			s.res.base_high <= pnpcr_pkg::RST_BASE_HIGH;
			s.res.base_low <= pnpcr_pkg::RST_BASE_LOW;
			s.res.irq_select <= pnpcr_pkg::RST_IRQ_SELECT;
			s.res.irq_type <= pnpcr_pkg::RST_IRQ_TYPE;
			s.res.dma0 <= pnpcr_pkg::RST_DMA0;
			s.res.dma1 <= pnpcr_pkg::RST_DMA1;
			s.res.device_config <= pnpcr_pkg::RST_DEVICE_CONFIG;
			s.res.drive_ident <= pnpcr_pkg::RST_DRIVE_IDENT;
			s.activate <= pnpcr_pkg::RST_ACTIVATE;
			s.range_check <= pnpcr_pkg::RST_RANGE;
			s.dev_enable <= 4'h0;
			s.strap_done <= 1'b0;
			s.rdata <= 8'h00;
			s.rvalid <= 1'b0;
		end else begin
			s <= next_s;
		end
	end

	assign cfg_rdata_out = s.rdata;
	assign cfg_rvalid_out = s.rvalid;
	assign dev_enable_out = s.dev_enable;
	assign res_out = s.res;

endmodule

// ==== pnpcr_regs_sva.sv ====
// assertions on the configuration register bank
// sees only the top module ports; bound at the foot of this file
`timescale 1ns/1ps
module pnpcr_regs_sva (
	input wire logic mclk_in,
	input wire logic nrst_in,
	input wire logic soft_reset_in,
	input wire logic [7:0] ldn_in,
	input wire logic [7:0] cfg_index_in,
	input wire logic cfg_rd_in,
	input wire logic [3:0] function_enable_one_in,
	input wire logic lpt_extended_mode_in,
	input wire logic [7:0] cfg_rdata_out,
	input wire logic cfg_rvalid_out,
	input wire logic [3:0] dev_enable_out,
	input wire pnpcr_pkg::pnpcr_res_s res_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!nrst_in);
	AST_RD_ANSWER: assert property (cfg_rd_in |=> cfg_rvalid_out)
		else $error("read not answered");
	AST_RD_QUIET: assert property (!cfg_rd_in |=> !cfg_rvalid_out)
		else $error("stray read valid");
	AST_FDC_LOW: assert property ((res_out.base_low[0] & 8'h05) == 8'h00)
		else $error("floppy base low bits set");
	AST_LPT_BASE: assert property (res_out.base_high[1][7:2] == 6'h00
		&& res_out.base_low[1][1:0] == 2'h0) else $error("lpt base bits");
	AST_SER_LOW: assert property (res_out.base_low[2][2:0] == 3'h0
		&& res_out.base_low[3][2:0] == 3'h0) else $error("serial base bits");
	AST_SER1_DMA: assert property (res_out.dma1[3] == 8'h04
		&& res_out.dma0[3] == 8'h04) else $error("serial1 dma not 04");
	AST_IRQ_TYPE: assert property ((res_out.irq_type[3] & 8'hFD) == 8'h01
		&& (res_out.irq_type[2] & 8'hFD) == 8'h01
		&& (res_out.irq_type[0] & 8'hFD) == 8'h01) else $error("irq type ro");
	AST_LPT_MODE: assert property (cfg_rd_in && ldn_in == 8'h04
		&& cfg_index_in == 8'h71 |=> cfg_rdata_out[7:2] == 6'h00
		&& cfg_rdata_out[0] == $past(lpt_extended_mode_in))
		else $error("lpt irq type read");
	AST_ENABLE: assert property ((dev_enable_out
		& ~$past(function_enable_one_in)) == 4'h0) else $error("enable leak");
	AST_SOFT_KEEP: assert property (soft_reset_in |=>
		$stable(res_out.device_config)
		&& res_out.base_low == pnpcr_pkg::RST_BASE_LOW)
		else $error("soft reset result");
endmodule
bind pnpcr_regs pnpcr_regs_sva pnpcr_regs_sva_inst (.mclk_in, .nrst_in,
	.soft_reset_in, .ldn_in, .cfg_index_in, .cfg_rd_in,
	.function_enable_one_in, .lpt_extended_mode_in, .cfg_rdata_out,
	.cfg_rvalid_out, .dev_enable_out, .res_out);

// ==== tb_pnpcr_regs.sv ====
// self-checking bench for the configuration register bank
// assumes the host model drives the port and the checker is bound
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
	$display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_pnpcr_regs;
	logic mclk_in = 1'b0, nrst_in = 1'b0, soft_reset_in = 1'b0;
	logic config_strap_zero_in = 1'b0, lpt_extended_mode_in = 1'b0;
	logic [3:0] function_enable_one_in = 4'hF, dev_enable_out;
	logic [7:0] ldn_in, cfg_index_in, cfg_wdata_in, cfg_rdata_out;
	logic cfg_wr_in, cfg_rd_in, cfg_rvalid_out;
	pnpcr_pkg::pnpcr_res_s res_out;
	int n_fail = 0, tests_run = 0;
	always #4 mclk_in = ~mclk_in;
	pnpcr_regs pnpcr_regs_inst (.mclk_in, .nrst_in, .soft_reset_in, .ldn_in,
		.cfg_index_in, .cfg_wdata_in, .cfg_wr_in, .cfg_rd_in,
		.config_strap_zero_in, .function_enable_one_in,
		.lpt_extended_mode_in, .cfg_rdata_out, .cfg_rvalid_out,
		.dev_enable_out, .res_out);
	pnpcr_host pnpcr_host_inst (.mclk_in, .rdata_in(cfg_rdata_out),
		.ldn_out(ldn_in), .index_out(cfg_index_in), .wdata_out(cfg_wdata_in),
		.wr_out(cfg_wr_in), .rd_out(cfg_rd_in));
	task automatic wr(input logic [7:0] l, i, d);
		pnpcr_host_inst.xfer(1'b1, l, i, d);
	endtask
	task automatic rchk(input logic [7:0] l, i, e);
		logic [7:0] v;
		pnpcr_host_inst.rd(l, i, v);
		`CHK($sformatf("ldn %h idx %h", l, i), e, v)
	endtask
	task automatic t_reset_values;
		logic [7:0] ix [7] = '{8'h31, 8'h60, 8'h61, 8'h70, 8'h71, 8'h74, 8'h75};
		pnpcr_pkg::pnpcr_bytes_t ex [7] = '{pnpcr_pkg::RST_RANGE,
			pnpcr_pkg::RST_BASE_HIGH, pnpcr_pkg::RST_BASE_LOW,
			pnpcr_pkg::RST_IRQ_SELECT, pnpcr_pkg::RST_IRQ_TYPE,
			pnpcr_pkg::RST_DMA0, pnpcr_pkg::RST_DMA1};
		for (int d = 0; d < 4; d++)
			for (int k = 0; k < 7; k++)
				rchk(8'(d + 3), ix[k], ex[k][d]);
		rchk(8'h03, 8'h30, 8'h00);
		rchk(8'h03, 8'h61, 8'hF2);
	endtask
	// all-ones then all-zeros expose the read-only bits
	task automatic t_write_masks;
		logic [7:0] lo [4] = '{8'hFA, 8'hFC, 8'hF8, 8'hF8};
		logic [7:0] it [4] = '{8'h03, 8'h02, 8'h03, 8'h03};
		for (int d = 0; d < 4; d++) begin
			wr(8'(d + 3), 8'h61, 8'hFF);
			wr(8'(d + 3), 8'h71, 8'hFF);
			rchk(8'(d + 3), 8'h61, lo[d]);
			rchk(8'(d + 3), 8'h71, it[d]);
			wr(8'(d + 3), 8'h71, 8'h00);
			rchk(8'(d + 3), 8'h71, it[d] & 8'h01);
		end
		wr(8'h04, 8'h60, 8'hFF);
		rchk(8'h04, 8'h60, 8'h03);
		wr(8'h05, 8'h74, 8'h01);
		wr(8'h05, 8'h75, 8'h02);
		rchk(8'h05, 8'h74, 8'h01);
		rchk(8'h05, 8'h75, 8'h02);
		wr(8'h06, 8'h74, 8'h00);
		rchk(8'h06, 8'h74, 8'h04);
		@(posedge mclk_in);
		#1 lpt_extended_mode_in = 1'b1;
		rchk(8'h04, 8'h71, 8'h01);
		#0 lpt_extended_mode_in = 1'b0;
	endtask
	task automatic t_enable;
		wr(8'h04, 8'h30, 8'h01);
		`CHK("lpt enable", 1'b1, dev_enable_out[1])
		function_enable_one_in = 4'hD;
		@(posedge mclk_in);
		#1 `CHK("lpt gated", 1'b0, dev_enable_out[1])
		rchk(8'h04, 8'h30, 8'h01);
		wr(8'h07, 8'h70, 8'h0F);
		rchk(8'h06, 8'h70, 8'h04);
	endtask
	// soft reset keeps F0h/F1h but reloads the rest and the strap
	task automatic t_soft;
		wr(8'h03, 8'hF0, 8'h5A);
		wr(8'h03, 8'hF1, 8'hA5);
		config_strap_zero_in = 1'b1;
		soft_reset_in = 1'b1;
		@(posedge mclk_in);
		#1 soft_reset_in = 1'b0;
		@(posedge mclk_in);
		rchk(8'h03, 8'hF0, 8'h5A);
		rchk(8'h03, 8'hF1, 8'hA5);
		rchk(8'h03, 8'h61, 8'hF2);
		rchk(8'h04, 8'h30, 8'h00);
		rchk(8'h03, 8'h30, 8'h01);
	endtask
	// mid-run hard reset clears F0h/F1h and samples the strap again
	task automatic t_hard;
		wr(8'h03, 8'hF0, 8'h3C);
		nrst_in = 1'b0;
		repeat (2) @(posedge mclk_in);
		#1 nrst_in = 1'b1;
		rchk(8'h03, 8'hF0, 8'h00);
		rchk(8'h03, 8'hF1, 8'h00);
		rchk(8'h03, 8'h30, 8'h01);
		rchk(8'h03, 8'h60, 8'h03);
	endtask
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// whole run is under two hundred cycles; this bound is far beyond it
	initial begin
		#200000;
		n_fail++;
		summarize();
	end
	initial begin
		repeat (10) @(posedge mclk_in);
		#1 nrst_in = 1'b1;
		t_reset_values();
		t_write_masks();
		t_enable();
		t_soft();
		t_hard();
		summarize();
	end
endmodule
